/* File: logic/msp_serial_cfg.sv */
// Serial port configuration, receive supervision, counters and indicators.
`timescale 1ns/1ns
module msp_serial_cfg #(
  parameter int BLINK = msp_pkg::BLINK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [msp_pkg::AW-1:0] addr_i,
  input wire logic [msp_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [msp_pkg::DW-1:0] rdata_o,
  output logic irq_o,
  input wire logic sup_rx_i,
  input wire logic sup_reply_i,
  output logic sup_tx_o,
  output msp_pkg::msp_port_cfg_t sup_cfg_o,
  output msp_pkg::msp_sup_opt_t sup_opt_o,
  output msp_pkg::msp_port_cfg_t eng_cfg_o,
  output logic eng_port_rst_o,
  output logic led_act_o,
  output logic led_sup_tx_o,
  output logic led_sup_rx_o,
  output logic led_status_o
);
  import msp_pkg::*;

  // Cycles per bit for a baud selection.
  function automatic logic [15:0] baud_div(input logic [1:0] sel);
    int rate;
    rate = 38400;
    if (sel == BAUD_4800) begin
      rate = 4800;
    end else if (sel == BAUD_9600) begin
      rate = 9600;
    end else if (sel == BAUD_19200) begin
      rate = 19200;
    end
    return 16'(CLK_HZ / rate);
  endfunction

  // One byte step of the reflected CRC-16.
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // A port setting is accepted only when its address and parity are legal.
  function automatic logic cfg_ok(input msp_port_cfg_t c);
    return (c.addr >= ADDR_MIN) && (c.addr <= ADDR_MAX) && (c.parity != 2'h3);
  endfunction

  msp_port_cfg_t sup_cfg_ff, eng_cfg_ff, wr_cfg;
  msp_sup_opt_t sup_opt_ff, wr_opt;
  msp_rx_state_t rx_st_ff;
  logic [EV_W-1:0] status_ff, mask_ff, ev;
  logic [15:0] valid_cnt_ff, invalid_cnt_ff, bit_cnt_ff, div, crc_ff;
  logic [23:0] sil_cnt_ff, sil_limit;
  logic [8:0] len_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_idx_ff;
  logic [2:0] sync_ff;
  logic rx_filt_ff, rx_mark, tick, par_bit_ff, char_done_ff, char_err_ff;
  logic in_frame_ff, frame_err_ff, port_rst_ff, configured_ff, cfg_err_ff, iface_err_ff;
  logic frame_end, frame_good, cnt_clr, sup_wr, eng_wr, ctrl_wr, st_rd;
  logic [31:0] blink_cnt_ff;
  logic blink_ff, rx_hold_ff, tx_hold_ff, tx_active;

  assign wr_cfg = msp_port_cfg_t'(wdata_i[11:0]);
  assign wr_opt = msp_sup_opt_t'(wdata_i[14:12]);
  assign sup_wr = wr_i && (addr_i == REG_SUP_CFG);
  assign eng_wr = wr_i && (addr_i == REG_ENG_CFG);
  assign ctrl_wr = wr_i && (addr_i == REG_CTRL) && wdata_i[0];
  assign st_rd = rd_i && (addr_i == REG_STATUS);

  // Configuration registers; illegal settings are refused and flagged.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sup_cfg_ff <= SUP_CFG_RST;
      sup_opt_ff <= SUP_OPT_RST;
      eng_cfg_ff <= ENG_CFG_RST;
      configured_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
      port_rst_ff <= 1'b0;
      eng_port_rst_o <= 1'b0;
    end else begin
      port_rst_ff <= 1'b0;
      eng_port_rst_o <= 1'b0;
      if (sup_wr || eng_wr) begin
        cfg_err_ff <= !cfg_ok(wr_cfg);
      end
      if (sup_wr && cfg_ok(wr_cfg)) begin
        configured_ff <= 1'b1;
        sup_cfg_ff <= wr_cfg;
        sup_opt_ff <= wr_opt;
        port_rst_ff <= (wr_cfg != sup_cfg_ff) || (wr_opt != sup_opt_ff);
      end
      if (eng_wr && cfg_ok(wr_cfg)) begin
        eng_cfg_ff <= wr_cfg;
        eng_port_rst_o <= (wr_cfg != eng_cfg_ff);
      end
    end
  end

  // Three-stage line synchroniser; a change counts when stages two and three agree.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // Reset to the dark idle level of the default polarity, so no false start follows reset.
      sync_ff <= 3'h0;
      rx_filt_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], sup_rx_i};
      if (sync_ff[1] == sync_ff[2]) begin
        rx_filt_ff <= sync_ff[2];
      end
    end
  end

  // Idle light level sets the polarity of the optical line.
  assign rx_mark = sup_opt_ff.idle_light ? rx_filt_ff : !rx_filt_ff;
  assign div = baud_div(sup_cfg_ff.baud);
  assign tick = (bit_cnt_ff == 16'h0000);
  // Silence threshold in cycles: three characters of 10 or 11 bits.
  assign sil_limit = 24'(SILENCE_CHARS) * 24'(DATA_BITS + 4'h2
    + ((sup_cfg_ff.parity == PAR_NONE) ? 4'h0 : 4'h1)) * 24'(div);

  // Character receiver, sampling each bit in its middle.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || port_rst_ff) begin
      rx_st_ff <= RX_IDLE;
      bit_cnt_ff <= 16'h0000;
      bit_idx_ff <= 3'h0;
      sh_ff <= 8'h00;
      par_bit_ff <= 1'b0;
      char_done_ff <= 1'b0;
      char_err_ff <= 1'b0;
    end else begin
      char_done_ff <= 1'b0;
      bit_cnt_ff <= tick ? div - 16'h0001 : bit_cnt_ff - 16'h0001;
      case (rx_st_ff)
        RX_IDLE: begin
          if (!rx_mark) begin
            bit_cnt_ff <= {1'b0, div[15:1]};
            rx_st_ff <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_st_ff <= rx_mark ? RX_IDLE : RX_DATA;
            bit_idx_ff <= 3'h0;
          end
        end
        RX_DATA: begin
          if (tick) begin
            sh_ff <= {rx_mark, sh_ff[7:1]};
            bit_idx_ff <= bit_idx_ff + 3'h1;
            if (bit_idx_ff == 3'h7) begin
              rx_st_ff <= (sup_cfg_ff.parity == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (tick) begin
            par_bit_ff <= rx_mark;
            rx_st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (tick) begin
            char_done_ff <= 1'b1;
            // Framing error on a low stop bit; parity checked as configured.
            char_err_ff <= !rx_mark
              || ((sup_cfg_ff.parity == PAR_EVEN) && ((^sh_ff) != par_bit_ff))
              || ((sup_cfg_ff.parity == PAR_ODD) && ((^sh_ff) == par_bit_ff));
            rx_st_ff <= RX_IDLE;
          end
        end
        default: begin
          rx_st_ff <= RX_IDLE;
        end
      endcase
    end
  end

  assign frame_end = in_frame_ff && (rx_st_ff == RX_IDLE) && (sil_cnt_ff > sil_limit);
  assign frame_good = !frame_err_ff && (len_ff <= FRAME_MAX) && (len_ff >= FRAME_MIN)
    && (crc_ff == 16'h0000);

  // Frame assembly: length, running CRC and any character error.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || port_rst_ff) begin
      sil_cnt_ff <= 24'h000000;
      in_frame_ff <= 1'b0;
      len_ff <= 9'h000;
      crc_ff <= CRC_INIT;
      frame_err_ff <= 1'b0;
      iface_err_ff <= 1'b0;
    end else begin
      if (rx_st_ff != RX_IDLE || char_done_ff) begin
        sil_cnt_ff <= 24'h000000;
      end else if (sil_cnt_ff <= sil_limit) begin
        sil_cnt_ff <= sil_cnt_ff + 24'h000001;
      end
      if (char_done_ff) begin
        if (char_err_ff && (sh_ff == 8'h00)) begin
          iface_err_ff <= 1'b1;
        end
        if (!in_frame_ff) begin
          in_frame_ff <= 1'b1;
          len_ff <= 9'h001;
          crc_ff <= crc_step(CRC_INIT, sh_ff);
          frame_err_ff <= char_err_ff;
        end else begin
          len_ff <= (len_ff > FRAME_MAX) ? len_ff : len_ff + 9'h001;
          crc_ff <= crc_step(crc_ff, sh_ff);
          frame_err_ff <= frame_err_ff || char_err_ff;
        end
      end else if (frame_end) begin
        in_frame_ff <= 1'b0;
      end
    end
  end

  // Diagnosis counters; they never hold the top value.
  assign cnt_clr = rst_i || port_rst_ff || ctrl_wr;
  always_ff @(posedge core_clk_i) begin
    if (cnt_clr) begin
      valid_cnt_ff <= 16'h0000;
      invalid_cnt_ff <= 16'h0000;
    end else if (frame_end) begin
      if (frame_good) begin
        valid_cnt_ff <= (valid_cnt_ff + 16'h0001 == CNT_MAX) ? 16'h0000
          : valid_cnt_ff + 16'h0001;
      end else begin
        invalid_cnt_ff <= (invalid_cnt_ff + 16'h0001 == CNT_MAX) ? 16'h0000
          : invalid_cnt_ff + 16'h0001;
      end
    end
  end

  // Sticky events; a new event wins over the clearing read.
  assign ev[EV_VALID] = frame_end && frame_good;
  assign ev[EV_INVALID] = frame_end && !frame_good;
  assign ev[EV_CFG_ERR] = (sup_wr || eng_wr) && !cfg_ok(wr_cfg);
  assign ev[EV_BREAK] = char_done_ff && char_err_ff && (sh_ff == 8'h00);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_ff <= '0;
      mask_ff <= '0;
      irq_o <= 1'b0;
    end else begin
      status_ff <= (st_rd ? '0 : status_ff) | ev;
      if (wr_i && (addr_i == REG_MASK)) begin
        mask_ff <= wdata_i[EV_W-1:0];
      end
      irq_o <= |(((st_rd ? '0 : status_ff) | ev) & mask_ff);
    end
  end

  // Register read port, data valid the cycle after the strobe.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i == REG_SUP_CFG) begin
        rdata_o <= {17'h00000, sup_opt_ff, sup_cfg_ff};
      end else if (addr_i == REG_ENG_CFG) begin
        rdata_o <= {20'h00000, eng_cfg_ff};
      end else if (addr_i == REG_VALID) begin
        rdata_o <= {16'h0000, valid_cnt_ff};
      end else if (addr_i == REG_INVALID) begin
        rdata_o <= {16'h0000, invalid_cnt_ff};
      end else if (addr_i == REG_STATUS) begin
        rdata_o <= {28'h0000000, status_ff};
      end else if (addr_i == REG_MASK) begin
        rdata_o <= {28'h0000000, mask_ff};
      end else if (addr_i == REG_CTRL) begin
        rdata_o <= {29'h00000000, iface_err_ff, cfg_err_ff, configured_ff};
      end else begin
        rdata_o <= '0;
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // Transmit line: reply merged with echoed receive traffic, in optical polarity.
  assign tx_active = !sup_reply_i || (sup_opt_ff.echo && !rx_mark);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sup_tx_o <= 1'b1;
    end else begin
      // Echo copies the request back; the master must drop it.
      sup_tx_o <= sup_opt_ff.idle_light ? !tx_active : tx_active;
    end
  end

  // Indicator blink base and activity stretch over one blink period.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      blink_cnt_ff <= 32'h00000000;
      blink_ff <= 1'b0;
      rx_hold_ff <= 1'b0;
      tx_hold_ff <= 1'b0;
    end else begin
      if (blink_cnt_ff >= 32'(BLINK - 1)) begin
        blink_cnt_ff <= 32'h00000000;
        blink_ff <= !blink_ff;
        rx_hold_ff <= (rx_st_ff != RX_IDLE);
        tx_hold_ff <= tx_active;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
        rx_hold_ff <= rx_hold_ff || (rx_st_ff != RX_IDLE);
        tx_hold_ff <= tx_hold_ff || tx_active;
      end
    end
  end

  // Indicator outputs and configuration mirrors.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      led_act_o <= 1'b0;
      led_sup_tx_o <= 1'b0;
      led_sup_rx_o <= 1'b0;
      led_status_o <= 1'b0;
      sup_cfg_o <= SUP_CFG_RST;
      sup_opt_o <= SUP_OPT_RST;
      eng_cfg_o <= ENG_CFG_RST;
    end else begin
      led_act_o <= (rx_hold_ff || tx_hold_ff) && blink_ff;
      led_sup_tx_o <= tx_hold_ff && blink_ff;
      led_sup_rx_o <= rx_hold_ff && blink_ff;
      led_status_o <= iface_err_ff || ((!configured_ff || cfg_err_ff) && blink_ff);
      sup_cfg_o <= sup_cfg_ff;
      sup_opt_o <= sup_opt_ff;
      eng_cfg_o <= eng_cfg_ff;
    end
  end
endmodule

/* File: pkg/msp_pkg.sv */
// Constants, register offsets and types for the serial port configuration block.
// How it works
// - Characters: eight data bits, one stop bit.
// - Supervision address 1 to 247, default 1.
// - Baud 4800/9600/19200/38400, default 19200.
// - Parity none/even/odd, default even, checked.
// - Fiber idle light level, default off.
// - Echo mode repeats received traffic, default off.
// - Direct or select-before-operate, default direct.
// - Engineering port own settings, 38400 odd.
// - Config change resets only that port.
// - Single activity indicator flashes on traffic.
// - Separate transmit and receive indicators flash.
// - Status indicator: off, flashing, or lit.
// - Valid and invalid frame counters readable.
// - Counters clear at FFFFh, command, change.
// - Invalid: CRC, over 255 bytes, character errors.
// - Over three character silence starts frame.
package msp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [AW-1:0] REG_SUP_CFG = 8'h00;
  localparam logic [AW-1:0] REG_ENG_CFG = 8'h04;
  localparam logic [AW-1:0] REG_VALID = 8'h08;
  localparam logic [AW-1:0] REG_INVALID = 8'h0c;
  localparam logic [AW-1:0] REG_STATUS = 8'h10;
  localparam logic [AW-1:0] REG_MASK = 8'h14;
  localparam logic [AW-1:0] REG_CTRL = 8'h18;
  localparam logic [1:0] BAUD_4800 = 2'h0;
  localparam logic [1:0] BAUD_9600 = 2'h1;
  localparam logic [1:0] BAUD_19200 = 2'h2;
  localparam logic [1:0] BAUD_38400 = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [8:0] FRAME_MAX = 9'h0ff;
  localparam logic [8:0] FRAME_MIN = 9'h004;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam int SILENCE_CHARS = 3;
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
  // Status and mask bit positions.
  localparam int EV_VALID = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_CFG_ERR = 2;
  localparam int EV_BREAK = 3;
  localparam int EV_W = 4;
  typedef struct packed {
    logic [7:0] addr;
    logic [1:0] baud;
    logic [1:0] parity;
  } msp_port_cfg_t;
  typedef struct packed {
    logic select_before_operate;
    logic echo;
    logic idle_light;
  } msp_sup_opt_t;
  localparam msp_port_cfg_t SUP_CFG_RST = '{addr: 8'h01, baud: BAUD_19200, parity: PAR_EVEN};
  localparam msp_port_cfg_t ENG_CFG_RST = '{addr: 8'h01, baud: BAUD_38400, parity: PAR_ODD};
  localparam msp_sup_opt_t SUP_OPT_RST = '{select_before_operate: 1'b0, echo: 1'b0, idle_light: 1'b0};
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_PAR = 3'b010,
    RX_STOP = 3'b110
  } msp_rx_state_t;
endpackage

/* File: tb/msp_master_model.sv */
// Behavioural bus master that drives characters onto the supervision line.
`timescale 1ns/1ns
module msp_master_model #(
  parameter int DIV = 6510
) (
  input wire logic core_clk_i,
  input wire logic idle_light_i,
  output logic line_o
);
  import msp_pkg::*;
  // The line rests at mark, which is dark while the idle light is off.
  initial line_o = 1'b0;
  // Sends start, eight data bits lowest first, parity if any, then stop.
  task automatic send_char(input logic [7:0] b, input logic [1:0] par, input logic flip);
    logic [10:0] bits;
    int n;
    bits = {1'b1, (^b) ^ (par == PAR_ODD) ^ flip, b, 1'b0};
    n = (par == PAR_NONE) ? 10 : 11;
    if (par == PAR_NONE) begin
      bits[9] = 1'b1;
    end
    for (int i = 0; i < n; i++) begin
      line_o <= ~(bits[i] ^ idle_light_i);
      repeat (DIV) @(posedge core_clk_i);
    end
  endtask
endmodule

/* File: tb/msp_serial_cfg_sva.sv */
// Concurrent checks on the ports of the serial port configuration block.
`timescale 1ns/1ns
module msp_serial_cfg_sva #(
  parameter int BLINK = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [msp_pkg::DW-1:0] rdata_o,
  input wire logic sup_rx_i,
  input wire logic sup_reply_i,
  input wire logic sup_tx_o,
  input wire msp_pkg::msp_port_cfg_t sup_cfg_o,
  input wire msp_pkg::msp_sup_opt_t sup_opt_o,
  input wire msp_pkg::msp_port_cfg_t eng_cfg_o,
  input wire logic eng_port_rst_o,
  input wire logic led_act_o,
  input wire logic led_sup_tx_o,
  input wire logic led_sup_rx_o
);
  import msp_pkg::*;
  int quiet_ff;
  int quiet_lim;
  // A quiet line must outlast a whole character plus eight blink periods.
  always_comb begin
    quiet_lim = 8 * BLINK + 40 + 12 * (CLK_HZ / 38400);
    if (sup_cfg_o.baud == BAUD_4800) begin
      quiet_lim = 8 * BLINK + 40 + 12 * (CLK_HZ / 4800);
    end else if (sup_cfg_o.baud == BAUD_9600) begin
      quiet_lim = 8 * BLINK + 40 + 12 * (CLK_HZ / 9600);
    end else if (sup_cfg_o.baud == BAUD_19200) begin
      quiet_lim = 8 * BLINK + 40 + 12 * (CLK_HZ / 19200);
    end
  end
  logic rx_q_ff;
  logic tx_q_ff;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Counts cycles without line movement or reply traffic, so stuck indicators show up.
  always_ff @(posedge core_clk_i) begin
    rx_q_ff <= sup_rx_i;
    tx_q_ff <= sup_tx_o;
    if (rst_i || rx_q_ff != sup_rx_i || tx_q_ff != sup_tx_o || !sup_reply_i) begin
      quiet_ff <= 0;
    end else if (quiet_ff < quiet_lim) begin
      quiet_ff <= quiet_ff + 1;
    end
  end
  // Checks hold the port settings legal and tie the other outputs to their causes.
  AST_SUP_ADDR:
  assert property (sup_cfg_o.addr >= ADDR_MIN && sup_cfg_o.addr <= ADDR_MAX)
    else $error("supervision address out of range");
  AST_SUP_PARITY:
  assert property (sup_cfg_o.parity != 2'h3) else $error("illegal supervision parity");
  AST_ENG_LEGAL:
  assert property (eng_cfg_o.addr >= ADDR_MIN && eng_cfg_o.addr <= ADDR_MAX
    && eng_cfg_o.parity != 2'h3) else $error("illegal engineering settings");
  AST_ENG_RST_ON_CHANGE:
  assert property ($changed(eng_cfg_o) |-> (eng_port_rst_o || $past(eng_port_rst_o))
    or ##1 eng_port_rst_o) else $error("engineering change without port reset");
  AST_ENG_RST_PULSE:
  assert property (eng_port_rst_o |=> !eng_port_rst_o) else $error("port reset too long");
  AST_TX_IDLE:
  assert property ((sup_reply_i && !sup_opt_o.echo && $stable(sup_opt_o))[*3]
    |-> sup_tx_o == sup_opt_o.idle_light) else $error("idle level wrong");
  AST_TX_REPLY:
  assert property ((!sup_reply_i && !sup_opt_o.echo && $stable(sup_opt_o))[*3]
    |-> sup_tx_o != sup_opt_o.idle_light) else $error("reply space not sent");
  AST_ECHO:
  assert property ((sup_opt_o.echo && sup_reply_i && $stable(sup_rx_i)
    && $stable(sup_opt_o))[*6] |-> sup_tx_o == sup_rx_i) else $error("echo missing");
  AST_RX_LED:
  assert property ($changed(sup_rx_i) |-> ##[1:40] led_sup_rx_o)
    else $error("receive indicator silent");
  AST_LEDS_QUIET:
  assert property (quiet_ff >= quiet_lim |-> !led_act_o && !led_sup_rx_o && !led_sup_tx_o)
    else $error("indicator lit on a quiet line");
  AST_RDATA_ZERO:
  assert property (!$past(rd_i) |-> rdata_o == '0) else $error("read data outside slot");
endmodule
bind msp_serial_cfg msp_serial_cfg_sva #(.BLINK(BLINK)) u_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .sup_rx_i(sup_rx_i), .sup_reply_i(sup_reply_i), .sup_tx_o(sup_tx_o),
  .sup_cfg_o(sup_cfg_o), .sup_opt_o(sup_opt_o), .eng_cfg_o(eng_cfg_o),
  .eng_port_rst_o(eng_port_rst_o), .led_act_o(led_act_o),
  .led_sup_tx_o(led_sup_tx_o), .led_sup_rx_o(led_sup_rx_o));

/* File: tb/tb_msp_serial_cfg.sv */
// Self-checking testbench for the serial port configuration block.
`timescale 1ns/1ns
module tb_msp_serial_cfg;
  import msp_pkg::*;
  localparam int DIV = CLK_HZ / 38400;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sup_reply_i = 1'b1;
  logic light = 1'b0;
  logic sup_rx_i;
  logic [DW-1:0] rdata_o;
  logic irq_o;
  logic sup_tx_o;
  msp_port_cfg_t sup_cfg_o;
  msp_sup_opt_t sup_opt_o;
  msp_port_cfg_t eng_cfg_o;
  logic eng_port_rst_o;
  logic led_act_o;
  logic led_sup_tx_o;
  logic led_sup_rx_o;
  logic led_status_o;
  int fail_count = 0;
  int compares = 0;
  logic [15:0] blink;
  logic [31:0] bad [3] = '{32'h000, 32'hf80, 32'h013};
  msp_serial_cfg #(.BLINK(8)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .sup_rx_i(sup_rx_i), .sup_reply_i(sup_reply_i), .sup_tx_o(sup_tx_o),
    .sup_cfg_o(sup_cfg_o), .sup_opt_o(sup_opt_o), .eng_cfg_o(eng_cfg_o),
    .eng_port_rst_o(eng_port_rst_o), .led_act_o(led_act_o), .led_sup_tx_o(led_sup_tx_o),
    .led_sup_rx_o(led_sup_rx_o), .led_status_o(led_status_o));
  msp_master_model #(.DIV(DIV)) u_mdl (.core_clk_i(core_clk_i), .idle_light_i(light),
    .line_o(sup_rx_i));
  // Free-running core clock.
  always #2 core_clk_i = ~core_clk_i;
  // Compares and counts; an unknown never matches.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write, then two edges for the effects to settle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  // One-cycle read; the data stand only in the following cycle.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
    repeat (2) @(posedge core_clk_i);
  endtask
  function automatic logic [31:0] cfgw(input logic [7:0] a, input logic [1:0] b,
      input logic [1:0] p, input logic [2:0] o);
    return {17'h0, o, a, b, p};
  endfunction
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // Four-byte frame with its check word, low byte first, then line silence.
  task automatic send_frame(input logic [1:0] par, input logic bad_crc, input logic flip);
    logic [15:0] c;
    c = crc16(16'h0801) ^ {15'h0, bad_crc};
    u_mdl.send_char(8'h01, par, flip);
    u_mdl.send_char(8'h08, par, 1'b0);
    u_mdl.send_char(c[7:0], par, 1'b0);
    u_mdl.send_char(c[15:8], par, 1'b0);
    repeat (35 * DIV) @(posedge core_clk_i);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short; the frames need about 8.3 milliseconds.
  initial begin
    #14_000_000;
    fail_count++;
    complete_run();
  end
  // Main test sequence.
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    #1 check(32'(sup_cfg_o), 32'(SUP_CFG_RST));
    check(32'(sup_opt_o), 32'(SUP_OPT_RST));
    check(32'(eng_cfg_o), 32'(ENG_CFG_RST));
    check(32'(sup_tx_o), 32'h0);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_i);
      blink[i] = led_status_o;
    end
    check(32'(blink != 16'h0 && blink != 16'hffff), 32'h1);
    rchk(REG_CTRL, 32'h0);
    rchk(8'h1c, 32'h0);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_SUP_CFG, cfgw(8'h01, 2'(i), 2'(i % 3), 3'h0));
      check(32'({sup_cfg_o.baud, sup_cfg_o.parity}), 32'({2'(i), 2'(i % 3)}));
    end
    foreach (bad[k]) begin
      wr(REG_SUP_CFG, bad[k]);
      check(32'(sup_cfg_o), 32'h01c);
    end
    check(32'(irq_o), 32'h0);
    wr(REG_MASK, 32'hf);
    check(32'(irq_o), 32'h1);
    rchk(REG_STATUS, 32'h4);
    check(32'(irq_o), 32'h0);
    rchk(REG_CTRL, 32'h3);
    wr(REG_SUP_CFG, cfgw(8'hf7, BAUD_38400, PAR_NONE, 3'h4));
    check(32'({sup_opt_o.select_before_operate, sup_cfg_o.addr}), 32'h1f7);
    repeat (20) @(posedge core_clk_i);
    check(32'(led_status_o), 32'h0);
    wr(REG_ENG_CFG, cfgw(8'h05, BAUD_9600, PAR_EVEN, 3'h0));
    check(32'(eng_cfg_o), 32'h055);
    check(32'(sup_cfg_o), 32'hf7c);
    $display("test settings done");
    send_frame(PAR_NONE, 1'b0, 1'b0);
    rchk(REG_VALID, 32'h1);
    check(32'(irq_o), 32'h1);
    rchk(REG_STATUS, 32'h1);
    send_frame(PAR_NONE, 1'b1, 1'b0);
    rchk(REG_INVALID, 32'h1);
    wr(REG_SUP_CFG, cfgw(8'hf7, BAUD_38400, PAR_EVEN, 3'h4));
    rchk(REG_VALID, 32'h0);
    send_frame(PAR_EVEN, 1'b0, 1'b0);
    rchk(REG_VALID, 32'h1);
    send_frame(PAR_EVEN, 1'b0, 1'b1);
    rchk(REG_INVALID, 32'h1);
    wr(REG_CTRL, 32'h1);
    rchk(REG_VALID, 32'h0);
    rchk(REG_INVALID, 32'h0);
    $display("test frames done");
    sup_reply_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    check(32'(sup_tx_o), 32'h1);
    sup_reply_i <= 1'b1;
    wr(REG_SUP_CFG, cfgw(8'hf7, BAUD_38400, PAR_EVEN, 3'h1));
    check(32'(sup_tx_o), 32'h1);
    wr(REG_SUP_CFG, cfgw(8'hf7, BAUD_38400, PAR_EVEN, 3'h2));
    check(32'(sup_opt_o.echo), 32'h1);
    u_mdl.send_char(8'h55, PAR_EVEN, 1'b0);
    $display("test line done");
    complete_run();
  end
endmodule
